// >>> rtl/bst_map.svh
// constants for the boundary-scan test port
`ifndef BST_MAP_SVH
`define BST_MAP_SVH
`define BST_IR_W        3
`define BST_BSR_W       109
`define BST_OE_CELL     108
`define BST_ID_W        32
`define BST_OP_EXTEST   3'h0
`define BST_OP_IDCODE   3'h1
`define BST_OP_SAMPLE_Z 3'h2
`define BST_OP_PRELOAD  3'h4
`define BST_OP_BYPASS   3'h7
`define BST_IR_CAPTURE  3'h1
`define BST_ID_VALUE    32'h1abc_d001
`define BST_RST_TMS_N   3'h5
`endif

// >>> rtl/bst_pkg.sv
// types for the boundary-scan test port
package bst_pkg;
   typedef enum logic [3:0] {
      BST_RESET      = 4'h0,
      BST_IDLE       = 4'h1,
      BST_SEL_DR     = 4'h2,
      BST_CAP_DR     = 4'h3,
      BST_SHIFT_DR   = 4'h4,
      BST_EXIT1_DR   = 4'h5,
      BST_PAUSE_DR   = 4'h6,
      BST_EXIT2_DR   = 4'h7,
      BST_UPD_DR     = 4'h8,
      BST_SEL_IR     = 4'h9,
      BST_CAP_IR     = 4'ha,
      BST_SHIFT_IR   = 4'hb,
      BST_EXIT1_IR   = 4'hc,
      BST_PAUSE_IR   = 4'hd,
      BST_EXIT2_IR   = 4'he,
      BST_UPD_IR     = 4'hf
   } bst_state_t;
   typedef enum logic [1:0] {
      BST_SEL_BYP = 2'h0,
      BST_SEL_ID  = 2'h1,
      BST_SEL_BSR = 2'h2
   } bst_dsel_t;
endpackage : bst_pkg

// >>> rtl/bst_tck_sync.sv
// test clock pin synchroniser with edge detection and pulled-up tms and tdi inputs
`timescale 1ns/100ps
`include "bst_map.svh"
module bst_tck_sync
   import bst_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic tck_pin,
   input  wire logic tms_pin,
   input  wire logic tms_pin_valid,
   input  wire logic tdi_pin,
   input  wire logic tdi_pin_valid,
   output logic      tck_rise,
   output logic      tck_fall,
   output logic      tms_s,
   output logic      tdi_s
);
   logic [1:0] tck_meta;
   logic [1:0] tms_meta;
   logic [1:0] tdi_meta;
   logic [1:0] tms_ok_meta;
   logic [1:0] tdi_ok_meta;
   logic       tck_last;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tck_meta <= 2'h0;
         tms_meta <= 2'h3;
         tdi_meta <= 2'h3;
         tms_ok_meta <= 2'h0;
         tdi_ok_meta <= 2'h0;
         tck_last <= 1'b0;
      end
      else
      begin
         tck_meta <= {tck_meta[0], tck_pin};
         tms_meta <= {tms_meta[0], tms_pin};
         tdi_meta <= {tdi_meta[0], tdi_pin};
         tms_ok_meta <= {tms_ok_meta[0], tms_pin_valid};
         tdi_ok_meta <= {tdi_ok_meta[0], tdi_pin_valid};
         tck_last <= tck_meta[1];
      end
   end

   assign tck_rise = tck_meta[1] & ~tck_last;
   assign tck_fall = ~tck_meta[1] & tck_last;
   // floating pins read as high, decided after the synchroniser
   assign tms_s    = tms_meta[1] | ~tms_ok_meta[1];
   assign tdi_s    = tdi_meta[1] | ~tdi_ok_meta[1];
endmodule : bst_tck_sync

// >>> rtl/bst_test_port.sv
// boundary-scan test port: controller, instruction, bypass, id and boundary registers
`timescale 1ns/100ps
`include "bst_map.svh"
module bst_test_port
   import bst_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tms_valid,
   input  wire logic                  tdi,
   input  wire logic                  tdi_valid,
   output logic                       tdo,
   output logic                       tdo_oe_n,
   input  wire logic [`BST_BSR_W-1:0] pin_ring,
   output logic [`BST_BSR_W-1:0]      preload_out,
   output logic                       extest_drive,
   output logic                       q_bus_oe_n
);
   bst_state_t              state;
   bst_state_t              next_state;
   logic                    tck_rise;
   logic                    tck_fall;
   logic                    tms_s;
   logic                    tdi_s;
   logic [`BST_IR_W-1:0]    ir_shift;
   logic [`BST_IR_W-1:0]    ir_cur;
   logic                    bypass;
   logic [`BST_ID_W-1:0]    id_shift;
   logic [`BST_BSR_W-1:0]   bsr_shift;
   logic [2:0]              tms_high_cnt;
   logic                    serial_out;
   logic                    enter_reset;
   bst_dsel_t               dsel;

   //////////////////////////////////////////////////////////////////////////////
   // pin sampling

   bst_tck_sync u_sync
   (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .tck_pin       (tck),
      .tms_pin       (tms),
      .tms_pin_valid (tms_valid),
      .tdi_pin       (tdi),
      .tdi_pin_valid (tdi_valid),
      .tck_rise      (tck_rise),
      .tck_fall      (tck_fall),
      .tms_s         (tms_s),
      .tdi_s         (tdi_s)
   );

   //////////////////////////////////////////////////////////////////////////////
   // decoding

   // data register chosen by instruction, reserved codes to bypass
   function automatic bst_dsel_t decode_sel(input logic [`BST_IR_W-1:0] op);
      bst_dsel_t s;
      s = BST_SEL_BYP;
      case (op)
         `BST_OP_IDCODE:   s = BST_SEL_ID;
         `BST_OP_EXTEST,
         `BST_OP_SAMPLE_Z,
         `BST_OP_PRELOAD:  s = BST_SEL_BSR;
         default:          s = BST_SEL_BYP;
      endcase
      return s;
   endfunction : decode_sel

   assign dsel = decode_sel(ir_cur);

   //////////////////////////////////////////////////////////////////////////////
   // controller

   always_comb
   begin
      next_state = state;
      unique case (state)
         BST_RESET:    next_state = tms_s ? BST_RESET : BST_IDLE;
         BST_IDLE:     next_state = tms_s ? BST_SEL_DR : BST_IDLE;
         BST_SEL_DR:   next_state = tms_s ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR:   next_state = tms_s ? BST_EXIT1_DR : BST_SHIFT_DR;
         BST_SHIFT_DR: next_state = tms_s ? BST_EXIT1_DR : BST_SHIFT_DR;
         BST_EXIT1_DR: next_state = tms_s ? BST_UPD_DR : BST_PAUSE_DR;
         BST_PAUSE_DR: next_state = tms_s ? BST_EXIT2_DR : BST_PAUSE_DR;
         BST_EXIT2_DR: next_state = tms_s ? BST_UPD_DR : BST_SHIFT_DR;
         BST_UPD_DR:   next_state = tms_s ? BST_SEL_DR : BST_IDLE;
         BST_SEL_IR:   next_state = tms_s ? BST_RESET : BST_CAP_IR;
         BST_CAP_IR:   next_state = tms_s ? BST_EXIT1_IR : BST_SHIFT_IR;
         BST_SHIFT_IR: next_state = tms_s ? BST_EXIT1_IR : BST_SHIFT_IR;
         BST_EXIT1_IR: next_state = tms_s ? BST_UPD_IR : BST_PAUSE_IR;
         BST_PAUSE_IR: next_state = tms_s ? BST_EXIT2_IR : BST_PAUSE_IR;
         BST_EXIT2_IR: next_state = tms_s ? BST_UPD_IR : BST_SHIFT_IR;
         BST_UPD_IR:   next_state = tms_s ? BST_SEL_DR : BST_IDLE;
      endcase
   end

   // reset entry by the state walk or by the five-rise backstop
   assign enter_reset = (next_state == BST_RESET) ||
                        (tms_s && tms_high_cnt == `BST_RST_TMS_N - 3'h1);

   // counts rising edges with tms high as a backstop to the state walk
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         tms_high_cnt <= 3'h0;
      else if (tck_rise)
         tms_high_cnt <= !tms_s ? 3'h0 :
                         (tms_high_cnt == `BST_RST_TMS_N) ? tms_high_cnt : tms_high_cnt + 3'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state <= BST_RESET;
      else if (tck_rise)
      begin
         if (enter_reset)
            state <= BST_RESET;
         else
            state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // instruction register

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ir_shift <= `BST_OP_IDCODE;
      else if (tck_rise)
      begin
         if (state == BST_CAP_IR)
            ir_shift <= `BST_IR_CAPTURE;
         else if (state == BST_SHIFT_IR)
            ir_shift <= {tdi_s, ir_shift[`BST_IR_W-1:1]};
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ir_cur <= `BST_OP_IDCODE;
      else if (tck_rise)
      begin
         if (enter_reset)
            ir_cur <= `BST_OP_IDCODE;
         else if (state == BST_UPD_IR)
            ir_cur <= ir_shift;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // data registers

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         bypass <= 1'b0;
      else if (tck_rise)
      begin
         if (state == BST_UPD_IR && decode_sel(ir_shift) == BST_SEL_BYP)
            bypass <= 1'b0;
         else if (state == BST_CAP_DR && dsel == BST_SEL_BYP)
            bypass <= 1'b0;
         else if (state == BST_SHIFT_DR && dsel == BST_SEL_BYP)
            bypass <= tdi_s;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         id_shift <= `BST_ID_VALUE;
      else if (tck_rise && dsel == BST_SEL_ID)
      begin
         if (state == BST_CAP_DR)
            id_shift <= `BST_ID_VALUE;
         else if (state == BST_SHIFT_DR)
            id_shift <= {tdi_s, id_shift[`BST_ID_W-1:1]};
      end
   end

   // spare cells for absent pins sit in pin_ring and read as sampled
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         bsr_shift <= '0;
      else if (tck_rise && dsel == BST_SEL_BSR)
      begin
         if (state == BST_CAP_DR)
            bsr_shift <= pin_ring;
         else if (state == BST_SHIFT_DR)
            bsr_shift <= {tdi_s, bsr_shift[`BST_BSR_W-1:1]};
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         preload_out <= '0;
      else if (tck_rise)
      begin
         if (enter_reset)
            preload_out[`BST_OE_CELL] <= 1'b0;
         else if (state == BST_UPD_DR && dsel == BST_SEL_BSR)
            preload_out <= bsr_shift;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // output drive control

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         extest_drive <= 1'b0;
         q_bus_oe_n   <= 1'b0;
      end
      else
      begin
         extest_drive <= (ir_cur == `BST_OP_EXTEST);
         if (ir_cur == `BST_OP_SAMPLE_Z)
            q_bus_oe_n <= 1'b1;
         else if (ir_cur == `BST_OP_EXTEST)
            q_bus_oe_n <= ~preload_out[`BST_OE_CELL];
         else
            q_bus_oe_n <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // serial out on falling edge

   always_comb
   begin
      serial_out = bypass;
      if (state == BST_SHIFT_IR)
         serial_out = ir_shift[0];
      else
         unique case (dsel)
            BST_SEL_ID:  serial_out = id_shift[0];
            BST_SEL_BSR: serial_out = bsr_shift[0];
            BST_SEL_BYP: serial_out = bypass;
            default:     serial_out = bypass;
         endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tdo      <= 1'b0;
         tdo_oe_n <= 1'b1;
      end
      else if (tck_fall)
      begin
         tdo      <= serial_out;
         tdo_oe_n <= !(state == BST_SHIFT_DR || state == BST_SHIFT_IR);
      end
   end
endmodule : bst_test_port

// >>> tb/bst_jtag_host.sv
// scan controller model: drives the test pins, reads tdo
`timescale 1ns/100ps
module bst_jtag_host
(
   input  wire logic sys_clk,
   input  wire logic tdo,
   input  wire logic tdo_oe_n,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one 160 ns test clock period, tdo read just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge sys_clk);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge sys_clk);
      // a released tdo reads as the inverse of its last value
      o = tdo_oe_n ? !tdo : tdo;
      tck <= 1'b1;
      repeat (8) @(posedge sys_clk);
      tck <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : step
endmodule : bst_jtag_host

// >>> tb/bst_test_port_assertions.sv
// checker on the boundary-scan test port pins
`timescale 1ns/100ps
`include "bst_map.svh"
module bst_test_port_assertions
(
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  tck,
   input wire logic                  tms,
   input wire logic                  tms_valid,
   input wire logic                  tdo,
   input wire logic                  tdo_oe_n,
   input wire logic [`BST_BSR_W-1:0] preload_out,
   input wire logic                  extest_drive,
   input wire logic                  q_bus_oe_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   logic [2:0] ones;
   logic [2:0] hi;
   logic [2:0] lo;
   ////////////////////////////////////////////////////////////
   // ages of the test clock phases and count of tms-high rises
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ones <= 3'h0;
         hi   <= 3'h0;
         lo   <= 3'h0;
      end
      else
      begin
         hi <= tck ? hi + {2'h0, hi != 3'h7} : 3'h0;
         lo <= tck ? 3'h0 : lo + {2'h0, lo != 3'h7};
         if (tck && hi == 3'h0)
            ones <= (tms || !tms_valid) ? ones + {2'h0, ones != 3'h7} : 3'h0;
      end
   end
   ////////////////////////////////////////////////////////////
   rst_quiet_a:
   assert property ($fell(rst) |-> !extest_drive && !q_bus_oe_n && preload_out == '0)
      else $error("outputs not quiet after reset");
   pwr_hiz_a:
   assert property ($fell(rst) |-> tdo_oe_n [*8]) else $error("tdo driven after reset");
   tdo_fall_a:
   assert property ($changed(tdo) |-> lo inside {[3'h1:3'h6]}) else $error("tdo off fall");
   oe_fall_a:
   assert property ($changed(tdo_oe_n) |-> lo inside {[3'h1:3'h6]}) else $error("oe off fall");
   five_high_a:
   assert property (ones == 3'h5 |-> ##8 tdo_oe_n && !extest_drive && !q_bus_oe_n
                    && !preload_out[`BST_OE_CELL]) else $error("no reset after five");
   ir_update_a:
   assert property ($changed(extest_drive) || $changed(q_bus_oe_n) |-> hi inside {[3'h1:3'h6]})
      else $error("instruction effect off rise");
   preload_upd_a:
   assert property ($changed(preload_out) |-> hi inside {[3'h1:3'h6]}) else $error("preload off rise");
   ext_oe_a:
   assert property (extest_drive && $past(extest_drive) && $stable(preload_out[`BST_OE_CELL])
                    |-> q_bus_oe_n == !preload_out[`BST_OE_CELL]) else $error("bad bus enable");
   cover property (ones == 3'h5);
   cover property (extest_drive && !q_bus_oe_n);
   cover property (!tdo_oe_n);
endmodule : bst_test_port_assertions

// >>> tb/bst_test_port_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`include "bst_map.svh"
module bst_test_port_tb;
   logic                  sys_clk;
   logic                  rst;
   logic                  tck;
   logic                  tms;
   logic                  tms_valid;
   logic                  tdi;
   logic                  tdi_valid;
   logic                  tdo;
   logic                  tdo_oe_n;
   logic                  extest_drive;
   logic                  q_bus_oe_n;
   logic                  sh_oe;
   logic [`BST_BSR_W-1:0] pin_ring;
   logic [`BST_BSR_W-1:0] preload_out;
   logic [`BST_BSR_W-1:0] v;
   logic [`BST_BSR_W-1:0] pat;
   int                    miscompares;
   int                    n_tests;
   bst_test_port dut (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tms_valid(tms_valid),
      .tdi(tdi), .tdi_valid(tdi_valid), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_ring(pin_ring),
      .preload_out(preload_out), .extest_drive(extest_drive), .q_bus_oe_n(q_bus_oe_n));
   bst_jtag_host host (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms),
      .tdi(tdi));
   ////////////////////////////////////////////////////////////
   task automatic check(input string s, input logic [`BST_BSR_W-1:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask : check
   task automatic conclude;
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // from idle through one ir or dr scan of n bits and back to idle
   task automatic scan(input logic ir, input int n, input logic [`BST_BSR_W-1:0] din);
      logic o;
      v = '0;
      host.step(1'b1, 1'b0, o);
      if (ir)
         host.step(1'b1, 1'b0, o);
      host.step(1'b0, 1'b0, o);
      host.step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++)
      begin
         host.step(i == n - 1, din[i], o);
         v[i] = o;
         if (i == 0)
            #15 sh_oe = tdo_oe_n;
      end
      host.step(1'b1, 1'b0, o);
      host.step(1'b0, 1'b0, o);
   endtask : scan
   ////////////////////////////////////////////////////////////
   task automatic t_idcode;
      scan(1'b0, 32, '1);
      check("id", `BST_ID_VALUE, v);
      check("oe shift", 1'b0, sh_oe);
      check("oe idle", 1'b1, tdo_oe_n);
   endtask : t_idcode
   task automatic t_bypass;
      logic [2:0] op [3] = '{3'h3, 3'h5, 3'h6};
      scan(1'b1, 3, `BST_OP_BYPASS);
      check("ir capture", 2'h1, v[1:0]);
      scan(1'b0, 4, 4'h7);
      check("bypass", 4'he, v);
      foreach (op[k])
      begin
         scan(1'b1, 3, op[k]);
         scan(1'b0, 2, 2'h1);
         check("reserved", 2'h2, v);
      end
   endtask : t_bypass
   task automatic t_bsr;
      pat = {1'b1, {27{4'h6}}};
      scan(1'b1, 3, `BST_OP_PRELOAD);
      scan(1'b0, `BST_BSR_W, pat);
      check("preload capture", pin_ring, v);
      check("preload latch", pat, preload_out);
      pin_ring <= ~pin_ring;
      scan(1'b1, 3, `BST_OP_SAMPLE_Z);
      check("sample z off", 1'b1, q_bus_oe_n);
      scan(1'b0, `BST_BSR_W, pat);
      check("sample z capture", pin_ring, v);
      check("sample z held", 1'b1, q_bus_oe_n);
      scan(1'b1, 3, `BST_OP_EXTEST);
      check("extest drive", 1'b1, extest_drive);
      check("extest on", 1'b0, q_bus_oe_n);
      scan(1'b0, `BST_BSR_W, {1'b0, pat[107:0]});
      check("extest capture", pin_ring, v);
      check("extest off", 1'b1, q_bus_oe_n);
   endtask : t_bsr
   task automatic t_float;
      logic o;
      scan(1'b1, 3, `BST_OP_BYPASS);
      tdi_valid <= 1'b0;
      scan(1'b0, 3, 3'h0);
      check("floating tdi", 3'h6, v);
      tdi_valid <= 1'b1;
      scan(1'b1, 3, `BST_OP_EXTEST);
      check("extest before reset", 1'b1, extest_drive);
      host.step(1'b1, 1'b0, o);
      host.step(1'b0, 1'b0, o);
      host.step(1'b0, 1'b0, o);
      tms_valid <= 1'b0;
      repeat (5) host.step(1'b0, 1'b0, o);
      check("float tms reset", 1'b1, tdo_oe_n);
      check("reset extest", 1'b0, extest_drive);
      check("reset bus enable", 1'b0, q_bus_oe_n);
      check("reset oe cell", 1'b0, preload_out[`BST_OE_CELL]);
      tms_valid <= 1'b1;
      host.step(1'b0, 1'b0, o);
      t_idcode;
   endtask : t_float
   ////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #500_000;
      miscompares++;
      conclude;
   end
   initial
   begin
      logic o;
      rst = 1'b1;
      tms_valid = 1'b1;
      tdi_valid = 1'b1;
      pin_ring = {1'b0, {27{4'h9}}};
      miscompares = 0;
      n_tests = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      check("oe reset", 1'b1, tdo_oe_n);
      host.step(1'b0, 1'b0, o);
      t_idcode;
      t_bypass;
      t_bsr;
      t_float;
      conclude;
   end
endmodule : bst_test_port_tb
bind bst_test_port bst_test_port_assertions chk (.sys_clk(sys_clk), .rst(rst), .tck(tck),
   .tms(tms), .tms_valid(tms_valid), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .preload_out(preload_out),
   .extest_drive(extest_drive), .q_bus_oe_n(q_bus_oe_n));
